// ==== logic/cmpev_top.sv ====
// Comparator event logic: APB registers, triggers, interrupt status, pin output
`timescale 1ns/1ns
`default_nettype none
module cmpev_top #(
   parameter int N_CMP = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N_CMP-1:0] cmp_result,
   output logic [N_CMP-1:0] cmp_pin_out,
   output logic [N_CMP-1:0] cmp_pin_out_en,
   output logic [N_CMP-1:0] adc_start_trigger,
   output logic [N_CMP-1:0] cmp_irq,
   output logic [2*N_CMP-1:0] ref_src_sel,
   output logic [4:0] ref_ladder_sel,
   output logic ref_ladder_en
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [N_CMP-1:0][15:0] cfg;
      logic [N_CMP-1:0] ris;
      logic [N_CMP-1:0] inten;
      logic [4:0] ref_code;
      logic [N_CMP-1:0] trig;
      logic [N_CMP-1:0] pin;
      logic [31:0] rdata;
   } cmpev_top_s;

   cmpev_top_s st_r;
   cmpev_top_s st_nxt;

   logic [N_CMP-1:0] lvl;
   logic [N_CMP-1:0] rse;
   logic [N_CMP-1:0] fal;

   // ****************************************
   // Synchronisers
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < N_CMP; gi++) begin : g_sync
         cmpev_sync_if sif ();
         cmpev_sync u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .async_in(cmp_result[gi]),
            .sync(sif.src)
         );
         assign lvl[gi] = sif.level;
         assign rse[gi] = sif.rise;
         assign fal[gi] = sif.fall;
      end
   endgenerate

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic sel_hit(input logic [2:0] sel, input logic l, input logic r, input logic f);
      logic hit;
      hit = 1'b0;
      case (sel)
         3'h1: hit = l;
         3'h2: hit = ~l;
         3'h3: hit = f;
         3'h4: hit = r;
         3'h5: hit = r | f;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : sel_hit

   function automatic logic is_level(input logic [2:0] sel);
      return (sel == cmpev_pkg::INT_SENSE_HIGH) || (sel == cmpev_pkg::INT_SENSE_LOW);
   endfunction : is_level

   // ****************************************
   // APB decode
   // ****************************************
   logic acc;
   logic wr;
   logic known;
   logic cfg_hit;
   logic [11:0] cfg_off;
   int cfg_idx;

   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign cfg_off = paddr - cmpev_pkg::CMPEV_OFF_CFG0;
   assign cfg_idx = int'(cfg_off[11:2]);
   assign cfg_hit = (paddr >= cmpev_pkg::CMPEV_OFF_CFG0) && (paddr[1:0] == 2'h0) && (cfg_idx < N_CMP);
   always_comb begin
      known = cfg_hit;
      case (paddr)
         cmpev_pkg::CMPEV_OFF_RIS,
         cmpev_pkg::CMPEV_OFF_MIS,
         cmpev_pkg::CMPEV_OFF_INTEN,
         cmpev_pkg::CMPEV_OFF_REFCTL,
         cmpev_pkg::CMPEV_OFF_VALUE: known = 1'b1;
         default: ;
      endcase
   end

   // Zero-wait slave; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = acc & ~known;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [2:0] tsel;
      logic [2:0] isel;
      logic [1:0] pol;
      logic hit;
      tsel = '0;
      isel = '0;
      pol = '0;
      hit = 1'b0;
      st_nxt = st_r;
      for (int i = 0; i < N_CMP; i++) begin
         tsel = st_r.cfg[i][cmpev_pkg::CMPEV_TRIG_LSB +: 3];
         isel = st_r.cfg[i][cmpev_pkg::CMPEV_ISNS_LSB +: 3];
         pol = st_r.cfg[i][cmpev_pkg::CMPEV_POL_LSB +: 2];
         // Separate selectors feed separate paths
         st_nxt.trig[i] = sel_hit(tsel, lvl[i], rse[i], fal[i]);
         // Legacy setting falls into the normal branch
         st_nxt.pin[i] = (pol == cmpev_pkg::POL_INVERT) ? ~lvl[i] : lvl[i];
         hit = sel_hit(isel, lvl[i], rse[i], fal[i]);
         if (wr && paddr == cmpev_pkg::CMPEV_OFF_RIS && pwdata[i]) begin
            st_nxt.ris[i] = 1'b0;
         end
         // Set beats clear; a live level re-asserts at once
         if (hit) begin
            st_nxt.ris[i] = 1'b1;
         end
         if (wr && cfg_hit && cfg_idx == i) begin
            st_nxt.cfg[i] = pwdata[15:0];
         end
      end
      if (wr && paddr == cmpev_pkg::CMPEV_OFF_INTEN) begin
         st_nxt.inten = pwdata[N_CMP-1:0];
      end
      if (wr && paddr == cmpev_pkg::CMPEV_OFF_REFCTL) begin
         st_nxt.ref_code = (pwdata[4:0] > cmpev_pkg::REF_TOP) ? cmpev_pkg::REF_TOP : pwdata[4:0];
      end
      st_nxt.rdata = '0;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            cmpev_pkg::CMPEV_OFF_RIS: st_nxt.rdata[N_CMP-1:0] = st_r.ris;
            cmpev_pkg::CMPEV_OFF_MIS: st_nxt.rdata[N_CMP-1:0] = st_r.ris & st_r.inten;
            cmpev_pkg::CMPEV_OFF_INTEN: st_nxt.rdata[N_CMP-1:0] = st_r.inten;
            cmpev_pkg::CMPEV_OFF_REFCTL: st_nxt.rdata[4:0] = st_r.ref_code;
            cmpev_pkg::CMPEV_OFF_VALUE: st_nxt.rdata[N_CMP-1:0] = lvl;
            default: begin
               if (cfg_hit) begin
                  st_nxt.rdata[15:0] = st_r.cfg[cfg_idx];
               end
            end
         endcase
      end else if (acc) begin
         st_nxt.rdata = st_r.rdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign prdata = st_r.rdata;
   assign adc_start_trigger = st_r.trig;
   assign cmp_pin_out = st_r.pin;
   assign cmp_pin_out_en = {N_CMP{1'b1}};
   // Masking only gates the output; raw stays intact
   assign cmp_irq = st_r.ris & st_r.inten;
   always_comb begin
      for (int i = 0; i < N_CMP; i++) begin
         ref_src_sel[2*i +: 2] = st_r.cfg[i][cmpev_pkg::CMPEV_SRC_LSB +: 2];
      end
   end
   assign ref_ladder_en = (st_r.ref_code != cmpev_pkg::REF_OFF);
   assign ref_ladder_sel = st_r.ref_code - 5'h01;

   // ****************************************
   // Checks
   // ****************************************
   property p_trig_off;
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg[0][2:0] == cmpev_pkg::ADC_TRIGGER_OFF) && $stable(st_r.cfg[0]) |=> !adc_start_trigger[0];
   endproperty
   a_trig_off: assert property (p_trig_off) else $error("trigger raised while off");

   property p_trig_level;
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg[1][2:0] == cmpev_pkg::ADC_TRIGGER_LEVEL_HIGH) && lvl[1] |=> adc_start_trigger[1];
   endproperty
   a_trig_level: assert property (p_trig_level) else $error("level trigger missing");

   property p_trig_rise;
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg[0][2:0] == cmpev_pkg::ADC_TRIGGER_RISING_EDGE) && rse[0] |=> adc_start_trigger[0] ##1
         (!adc_start_trigger[0] || ($past(st_r.cfg[0][2:0]) != cmpev_pkg::ADC_TRIGGER_RISING_EDGE));
   endproperty
   a_trig_rise: assert property (p_trig_rise) else $error("rising trigger not one pulse");

   property p_irq_level;
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg[1][6:4] == cmpev_pkg::INT_SENSE_HIGH) && lvl[1] |=> st_r.ris[1];
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("level status not held");

   property p_irq_edge;
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg[0][6:4] == cmpev_pkg::INT_SENSE_FALL) && fal[0] |=> st_r.ris[0];
   endproperty
   a_irq_edge: assert property (p_irq_edge) else $error("edge status not latched");

   property p_pin_pol;
      @(posedge pclk) disable iff (!presetn)
      $stable(st_r.cfg[0]) && $stable(lvl[0]) |->
         cmp_pin_out[0] == (lvl[0] ^ (st_r.cfg[0][13:12] == cmpev_pkg::POL_INVERT));
   endproperty
   a_pin_pol: assert property (p_pin_pol) else $error("pin polarity wrong");

   property p_mask;
      @(posedge pclk) disable iff (!presetn)
      !st_r.inten[0] |-> !cmp_irq[0];
   endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt forwarded");

   property p_clear;
      @(posedge pclk) disable iff (!presetn)
      wr && paddr == cmpev_pkg::CMPEV_OFF_RIS && pwdata[0] && !is_level(st_r.cfg[0][6:4])
         && !rse[0] && !fal[0] |=> !st_r.ris[0];
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not take");

   property p_trig_low;
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg[2][2:0] == cmpev_pkg::ADC_TRIGGER_LEVEL_LOW) && !lvl[2] |=> adc_start_trigger[2];
   endproperty
   a_trig_low: assert property (p_trig_low) else $error("low level trigger missing");

   property p_trig_fall;
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg[2][2:0] == cmpev_pkg::ADC_TRIGGER_FALLING_EDGE) && fal[2] |=> adc_start_trigger[2];
   endproperty
   a_trig_fall: assert property (p_trig_fall) else $error("falling trigger missing");

   property p_trig_any;
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg[2][2:0] == cmpev_pkg::ADC_TRIGGER_ANY_EDGE) && (rse[2] || fal[2]) |=> adc_start_trigger[2];
   endproperty
   a_trig_any: assert property (p_trig_any) else $error("any edge trigger missing");

   property p_irq_no_spurious;
      @(posedge pclk) disable iff (!presetn)
      (st_r.cfg[0][6:4] == cmpev_pkg::INT_SENSE_FALL) && !fal[0] && !st_r.ris[0] |=> !st_r.ris[0];
   endproperty
   a_irq_no_spurious: assert property (p_irq_no_spurious) else $error("status set without edge");

   property p_raw_kept;
      @(posedge pclk) disable iff (!presetn)
      !st_r.inten[0] && st_r.ris[0] && !(wr && paddr == cmpev_pkg::CMPEV_OFF_RIS && pwdata[0]) |=> st_r.ris[0];
   endproperty
   a_raw_kept: assert property (p_raw_kept) else $error("raw status lost while masked");

   property p_level_hold;
      @(posedge pclk) disable iff (!presetn)
      wr && paddr == cmpev_pkg::CMPEV_OFF_RIS && pwdata[1] && (st_r.cfg[1][6:4] == cmpev_pkg::INT_SENSE_HIGH)
         && lvl[1] |=> st_r.ris[1];
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("clear dropped live level status");

endmodule : cmpev_top
`default_nettype wire

// ==== logic/cmpev_pkg.sv ====
// Package of constants for the comparator event logic
package cmpev_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [11:0] CMPEV_OFF_RIS = 12'h000;
   localparam logic [11:0] CMPEV_OFF_MIS = 12'h004;
   localparam logic [11:0] CMPEV_OFF_INTEN = 12'h008;
   localparam logic [11:0] CMPEV_OFF_REFCTL = 12'h010;
   localparam logic [11:0] CMPEV_OFF_VALUE = 12'h014;
   localparam logic [11:0] CMPEV_OFF_CFG0 = 12'h020;
   localparam logic [11:0] CMPEV_CFG_STRIDE = 12'h004;

   // ****************************************
   // Per-comparator configuration fields
   // ****************************************
   localparam int CMPEV_TRIG_LSB = 0;
   localparam int CMPEV_ISNS_LSB = 4;
   localparam int CMPEV_SRC_LSB = 8;
   localparam int CMPEV_POL_LSB = 12;

   localparam logic [2:0] ADC_TRIGGER_OFF = 3'h0;
   localparam logic [2:0] ADC_TRIGGER_LEVEL_HIGH = 3'h1;
   localparam logic [2:0] ADC_TRIGGER_LEVEL_LOW = 3'h2;
   localparam logic [2:0] ADC_TRIGGER_FALLING_EDGE = 3'h3;
   localparam logic [2:0] ADC_TRIGGER_RISING_EDGE = 3'h4;
   localparam logic [2:0] ADC_TRIGGER_ANY_EDGE = 3'h5;

   localparam logic [2:0] INT_SENSE_HIGH = 3'h1;
   localparam logic [2:0] INT_SENSE_LOW = 3'h2;
   localparam logic [2:0] INT_SENSE_FALL = 3'h3;
   localparam logic [2:0] INT_SENSE_RISE = 3'h4;
   localparam logic [2:0] INT_SENSE_BOTH = 3'h5;

   localparam logic [1:0] REF_SRC_OWN_PIN = 2'h0;
   localparam logic [1:0] REF_SRC_SHARED_PIN_ZERO = 2'h1;
   localparam logic [1:0] REF_SRC_INTERNAL_LADDER = 2'h2;

   localparam logic [1:0] POL_NORMAL = 2'h0;
   localparam logic [1:0] POL_INVERT = 2'h1;
   localparam logic [1:0] POL_LEGACY_NONE = 2'h2;

   // Reference ladder: code 0 is off, codes 1..29 pick 0 V .. 2.371875 V
   localparam int CMPEV_REF_W = 5;
   localparam logic [4:0] REF_OFF = 5'h00;
   localparam logic [4:0] REF_TOP = 5'h1d;

   localparam logic [15:0] CMPEV_CFG_RESET = 16'h0000;
   localparam int CMPEV_SYNC_STAGES = 3;

endpackage : cmpev_pkg

// ==== logic/cmpev_sync_if.sv ====
// Interface carrying one synchronised comparator output and its edges
`timescale 1ns/1ns
`default_nettype none
interface cmpev_sync_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : cmpev_sync_if
`default_nettype wire

// ==== logic/cmpev_sync.sv ====
// Three-stage synchroniser with edge detection for one comparator output
`timescale 1ns/1ns
`default_nettype none
module cmpev_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic async_in,
   cmpev_sync_if.src sync
);
   typedef struct packed {
      logic [2:0] stg;
      logic level;
   } cmpev_sync_s;

   cmpev_sync_s st_r;
   cmpev_sync_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.stg = {st_r.stg[1:0], async_in};
      // Change counts once stages two and three agree
      if (st_r.stg[1] == st_r.stg[2]) begin
         st_nxt.level = st_r.stg[2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync.level = st_r.level;
   assign sync.rise = st_nxt.level & ~st_r.level;
   assign sync.fall = ~st_nxt.level & st_r.level;

   property p_sync_edge;
      @(posedge pclk) disable iff (!presetn)
      sync.rise |=> st_r.level;
   endproperty
   a_sync_edge: assert property (p_sync_edge) else $error("rise not followed by high level");
endmodule : cmpev_sync
`default_nettype wire

// ==== test/cmpev_far_model.sv ====
// Far side model: ADC sequencer start counter and interrupt controller input
`timescale 1ns/1ns
`default_nettype none
module cmpev_far_model #(
   parameter int N = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [N-1:0] adc_start_trigger,
   input wire logic [N-1:0] cmp_irq,
   output logic [8*N-1:0] trig_cnt,
   output logic [N-1:0] irq_pending
);
   logic [N-1:0] trig_d;
   // ****************************************
   // Sequencer starts and pending view
   // ****************************************
   // A held level starts the sequencer once, as a real sequencer would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_d <= '0;
         trig_cnt <= '0;
         irq_pending <= '0;
      end else begin
         trig_d <= adc_start_trigger;
         irq_pending <= cmp_irq;
         for (int i = 0; i < N; i++) begin
            if (adc_start_trigger[i] && !trig_d[i]) begin
               trig_cnt[8*i +: 8] <= trig_cnt[8*i +: 8] + 8'h01;
            end
         end
      end
   end
endmodule : cmpev_far_model
`default_nettype wire

// ==== test/test_comparator_event_logic.sv ====
// Testbench for the comparator event logic
`timescale 1ns/1ns
`default_nettype none
module test_comparator_event_logic;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [2:0] cmp_result = 3'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] pin_out;
   logic [2:0] pin_en;
   logic [2:0] trig;
   logic [2:0] irq;
   logic [2:0] irq_pend;
   logic [5:0] src_sel;
   logic [4:0] lad_sel;
   logic lad_en;
   logic [23:0] trig_cnt;
   logic [7:0] cnt;
   logic [31:0] rd;
   logic err;
   logic [7:0] exp_starts [6] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h02};
   int failures = 0;
   int checks = 0;

   always #2 pclk = ~pclk;

   cmpev_top #(.N_CMP(3)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_result(cmp_result), .cmp_pin_out(pin_out), .cmp_pin_out_en(pin_en),
      .adc_start_trigger(trig), .cmp_irq(irq), .ref_src_sel(src_sel), .ref_ladder_sel(lad_sel),
      .ref_ladder_en(lad_en));

   cmpev_far_model #(.N(3)) far (.pclk(pclk), .presetn(presetn), .adc_start_trigger(trig),
      .cmp_irq(irq), .trig_cnt(trig_cnt), .irq_pending(irq_pend));

   // ****************************************
   // Bus and compare tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Starts one edge later so no signal is assigned twice in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask : rchk

   // Covers sync depth plus the registered trigger and status stage
   task automatic settle;
      repeat (8) @(posedge pclk);
   endtask : settle

   function automatic logic [31:0] cfg(input logic [2:0] t, input logic [2:0] s, input logic [1:0] r,
      input logic [1:0] p);
      cfg = (32'(t) << cmpev_pkg::CMPEV_TRIG_LSB) | (32'(s) << cmpev_pkg::CMPEV_ISNS_LSB) |
         (32'(r) << cmpev_pkg::CMPEV_SRC_LSB) | (32'(p) << cmpev_pkg::CMPEV_POL_LSB);
   endfunction : cfg

   task automatic test_done;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rchk("unmapped read", 12'hffc, 32'h0);
      chk("unmapped error", 32'(err), 32'h1);
      $display("test bus done");
      apb(1'b1, cmpev_pkg::CMPEV_OFF_CFG0, cfg(cmpev_pkg::ADC_TRIGGER_RISING_EDGE,
         cmpev_pkg::INT_SENSE_FALL, cmpev_pkg::REF_SRC_INTERNAL_LADDER, cmpev_pkg::POL_INVERT));
      settle;
      chk("source 0", 32'(src_sel[1:0]), 32'h2);
      cnt = trig_cnt[7:0];
      cmp_result[0] <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("pin before sync", 32'(pin_out[0]), 32'h1);
      settle;
      chk("pin inverted", 32'(pin_out[0]), 32'h0);
      chk("rise starts", 32'(trig_cnt[7:0] - cnt), 32'h1);
      rchk("no status on rise", cmpev_pkg::CMPEV_OFF_RIS, 32'h0);
      rchk("value", cmpev_pkg::CMPEV_OFF_VALUE, 32'h1);
      cmp_result[0] <= 1'b0;
      settle;
      rchk("raw on fall", cmpev_pkg::CMPEV_OFF_RIS, 32'h1);
      rchk("masked off", cmpev_pkg::CMPEV_OFF_MIS, 32'h0);
      chk("irq masked", 32'(irq_pend), 32'h0);
      apb(1'b1, cmpev_pkg::CMPEV_OFF_INTEN, 32'h1);
      settle;
      rchk("masked on", cmpev_pkg::CMPEV_OFF_MIS, 32'h1);
      chk("irq forwarded", 32'(irq_pend), 32'h1);
      apb(1'b1, cmpev_pkg::CMPEV_OFF_RIS, 32'h1);
      settle;
      rchk("raw cleared", cmpev_pkg::CMPEV_OFF_RIS, 32'h0);
      chk("irq cleared", 32'(irq_pend), 32'h0);
      chk("no start on fall", 32'(trig_cnt[7:0] - cnt), 32'h1);
      $display("test edge unit done");
      apb(1'b1, cmpev_pkg::CMPEV_OFF_CFG0 + 12'h004, cfg(cmpev_pkg::ADC_TRIGGER_LEVEL_HIGH,
         cmpev_pkg::INT_SENSE_HIGH, cmpev_pkg::REF_SRC_SHARED_PIN_ZERO, cmpev_pkg::POL_LEGACY_NONE));
      cmp_result[1] <= 1'b1;
      settle;
      chk("level trigger", 32'(trig[1]), 32'h1);
      chk("legacy pin", 32'(pin_out[1]), 32'h1);
      chk("pins driven", 32'(pin_en), 32'h7);
      chk("source 1", 32'(src_sel[3:2]), 32'h1);
      apb(1'b1, cmpev_pkg::CMPEV_OFF_RIS, 32'h2);
      settle;
      rchk("level holds", cmpev_pkg::CMPEV_OFF_RIS, 32'h2);
      cmp_result[1] <= 1'b0;
      settle;
      chk("level trigger off", 32'(trig[1]), 32'h0);
      apb(1'b1, cmpev_pkg::CMPEV_OFF_RIS, 32'h2);
      settle;
      rchk("level gone", cmpev_pkg::CMPEV_OFF_RIS, 32'h0);
      $display("test level unit done");
      // Every trigger code: starts seen over one high pulse
      for (int k = 0; k < 6; k++) begin
         apb(1'b1, cmpev_pkg::CMPEV_OFF_CFG0 + 12'h008, cfg(3'(k), 3'h0, cmpev_pkg::REF_SRC_OWN_PIN,
            cmpev_pkg::POL_NORMAL));
         settle;
         cnt = trig_cnt[23:16];
         cmp_result[2] <= 1'b1;
         settle;
         cmp_result[2] <= 1'b0;
         settle;
         chk("starts per code", 32'(trig_cnt[23:16] - cnt), 32'(exp_starts[k]));
      end
      $display("test trigger codes done");
      apb(1'b1, cmpev_pkg::CMPEV_OFF_REFCTL, 32'h1);
      settle;
      chk("ladder lowest", 32'({lad_en, lad_sel}), 32'h20);
      apb(1'b1, cmpev_pkg::CMPEV_OFF_REFCTL, 32'(cmpev_pkg::REF_TOP));
      settle;
      chk("ladder top", 32'({lad_en, lad_sel}), 32'h3c);
      apb(1'b1, cmpev_pkg::CMPEV_OFF_REFCTL, 32'h0);
      settle;
      chk("ladder off", 32'(lad_en), 32'h0);
      $display("test ladder done");
      test_done;
   end

   // Tests need about 320 cycles; this allows ample margin
   initial begin
      #20000;
      failures++;
      test_done;
   end
endmodule : test_comparator_event_logic
`default_nettype wire
